// file: pww_pkg.sv
// package: constants for the power-on reset timer and window watchdog
package pww_pkg;

   // widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DIV_W  = 16;
   localparam int unsigned CNT_W  = 7;
   localparam int unsigned EV_W   = 4;
   localparam int unsigned SYNC_W = 7;

   // oscillator cycle counts
   localparam logic [CNT_W-1:0] POR_CYC    = 7'h40;
   localparam logic [CNT_W-1:0] HOLD_CYC   = 7'h21;
   localparam logic [CNT_W-1:0] WIN_LO_CYC = 7'h04;
   localparam logic [CNT_W-1:0] WIN_HI_CYC = 7'h40;

   // register byte offsets
   localparam logic [7:0] OFS_POR_DIV  = 8'h00;
   localparam logic [7:0] OFS_WDT_DIV  = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_INT_STAT = 8'h0c;
   localparam logic [7:0] OFS_INT_EN   = 8'h10;
   localparam logic [7:0] OFS_INT_CLR  = 8'h14;
   localparam logic [7:0] OFS_WD_CNT   = 8'h18;

   // reset values
   localparam logic [DIV_W-1:0] POR_DIV_RST = 16'h0004;
   localparam logic [DIV_W-1:0] WDT_DIV_RST = 16'h0004;
   localparam logic [EV_W-1:0]  INT_EN_RST  = 4'h0;

   // synchroniser lanes
   localparam int unsigned PIN_FB_HV = 0;
   localparam int unsigned PIN_FB_LV = 1;
   localparam int unsigned PIN_KICK  = 2;
   localparam int unsigned PIN_WDEN  = 3;
   localparam int unsigned PIN_HVRST = 4;
   localparam int unsigned PIN_LVRST = 5;
   localparam int unsigned PIN_WDO   = 6;

   // status register fields
   localparam int unsigned ST_FB_HV  = 0;
   localparam int unsigned ST_FB_LV  = 1;
   localparam int unsigned ST_HV_REL = 2;
   localparam int unsigned ST_LV_REL = 3;
   localparam int unsigned ST_WDEN   = 4;
   localparam int unsigned ST_KICK   = 5;
   localparam int unsigned ST_HVPIN  = 6;
   localparam int unsigned ST_LVPIN  = 7;
   localparam int unsigned ST_WDOPIN = 8;

   // event bits of status, enable and clear registers
   localparam int unsigned EV_HV_REL = 0;
   localparam int unsigned EV_LV_REL = 1;
   localparam int unsigned EV_FAULT  = 2;
   localparam int unsigned EV_KICK   = 3;

   // watchdog count register fields
   localparam int unsigned WC_STATE = 8;

   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'h0;

endpackage

// file: pww_sync.sv
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pww_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // a change counts only once stages two and three agree
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         o_q  <= '0;
      end else begin
         s1_q <= i_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         o_q  <= (s2_q & s3_q) | (o_q & (s2_q ^ s3_q));
      end
   end

endmodule

// file: pww_por_chan.sv
// module: power-on reset timeout for one regulator channel
`timescale 1ns/1ps
module pww_por_chan (
   input  wire logic i_clk_sys,
   input  wire logic i_srst,
   input  wire logic i_good,
   input  wire logic i_tick,
   output logic      o_released,
   output logic      o_osc_req
);
   import pww_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic             rel_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst || !i_good) begin // R18
         cnt_q <= '0;
         rel_q <= 1'b0;
      end else if (!rel_q && i_tick) begin
         if (cnt_q == POR_CYC - 7'h01) begin // R04
            cnt_q <= '0;
            rel_q <= 1'b1; // R05
         end else begin
            cnt_q <= cnt_q + 7'h01;
         end
      end
   end

   assign o_released = rel_q;
   // oscillator wanted only while good and still timing
   assign o_osc_req  = i_good && !rel_q; // R05

   property p_r18;
      @(posedge i_clk_sys) disable iff (i_srst)
      !i_good |=> !rel_q && cnt_q == '0;
   endproperty
   a_r18: assert property (p_r18) // R18
      else $error("reset not reasserted after good fell");

   property p_r04;
      @(posedge i_clk_sys) disable iff (i_srst)
      $rose(rel_q) |-> $past(cnt_q) == POR_CYC - 7'h01 && $past(i_tick);
   endproperty
   a_r04: assert property (p_r04) // R04
      else $error("reset released before 64 oscillator cycles");

   property p_r05;
      @(posedge i_clk_sys) disable iff (i_srst)
      rel_q && i_good |=> rel_q;
   endproperty
   a_r05: assert property (p_r05) // R05
      else $error("released reset fell back while good");

endmodule

// file: pww_top.sv
// module: dual power-on reset timer and window watchdog, ahb-lite slave
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
// Function
// R01 - each channel has its own good flag
// R02 - channel monitors watch from power-up onward
// R03 - reset outputs active-low open-drain, wired-or
// R04 - one shared oscillator, 64-cycle reset timeout
// R05 - good flag starts oscillator, then releases reset
// R06 - watchdog works only while enable pin high
// R07 - both released starts 33-cycle hold-off, kicks ignored
// R08 - only kick falling edges count as service
// R09 - kicks under 4 cycles apart are a fault
// R10 - 64 cycles without kick is a fault
// R11 - fault output low for 64 reset-oscillator cycles
// R12 - after fault release, hold-off restarts
// R13 - accepted kick restarts the watchdog count
// R14 - good kicks keep reset oscillator off, fault high
// R15 - fault output active-low open-drain like resets
// R16 - processor kicks between 4 and 64 cycles apart
// R17 - disabled watchdog idles, ignores kicks, fault released
// R18 - good flag drop reasserts reset, restarts timeout
// R19 - first interval measured from end of hold-off
module pww_top (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_srst,
   input  wire logic                          i_hsel,
   input  wire logic [pww_pkg::ADDR_W-1:0]    i_haddr,
   input  wire logic [1:0]                    i_htrans,
   input  wire logic                          i_hwrite,
   input  wire logic [2:0]                    i_hsize,
   input  wire logic                          i_hready,
   input  wire logic [pww_pkg::DATA_W-1:0]    i_hwdata,
   output logic      [pww_pkg::DATA_W-1:0]    o_hrdata,
   output logic                               o_hreadyout,
   output logic                               o_hresp,
   input  wire logic                          i_hv_feedback_good,
   input  wire logic                          i_lv_feedback_good,
   input  wire logic                          i_kick_input,
   input  wire logic                          i_watchdog_enable_pin,
   input  wire logic                          i_hv_channel_reset_n,
   output logic                               o_hv_channel_reset_n,
   output logic                               o_hv_channel_reset_n_oe_n,
   input  wire logic                          i_lv_channel_reset_n,
   output logic                               o_lv_channel_reset_n,
   output logic                               o_lv_channel_reset_n_oe_n,
   input  wire logic                          i_watchdog_fault_n,
   output logic                               o_watchdog_fault_n,
   output logic                               o_watchdog_fault_n_oe_n,
   output logic                               o_irq
);
   import pww_pkg::*;

   typedef enum logic [1:0] {WD_IDLE, WD_HOLD, WD_WIN, WD_FAULT} pww_wd_t;

   logic [SYNC_W-1:0] pin_s;
   logic              hv_good;
   logic              lv_good;
   logic              kick_s;
   logic              wden_s;
   logic              hv_rel;
   logic              lv_rel;
   logic              hv_req;
   logic              lv_req;
   logic              wd_ok;

   logic [DIV_W-1:0]  por_div_q;
   logic [DIV_W-1:0]  wdt_div_q;
   logic [DIV_W-1:0]  por_ph_q;
   logic [DIV_W-1:0]  wd_ph_q;
   logic              por_run;
   logic              por_tick;
   logic              wd_run;
   logic              wd_tick;

   pww_wd_t           wd_st_q;
   logic [CNT_W-1:0]  wd_cnt_q;
   logic              kick_prev_q;
   logic              kick_fall;
   logic              kick_acc;

   logic              zero_q;
   logic              hv_oe_n_q;
   logic              lv_oe_n_q;
   logic              wdo_oe_n_q;

   logic [EV_W-1:0]   int_stat_q;
   logic [EV_W-1:0]   int_en_q;
   logic [EV_W-1:0]   ev;
   logic [EV_W-1:0]   int_clr;
   logic              irq_q;

   logic              ap;
   logic              wr_q;
   logic [7:0]        wa_q;
   logic [DATA_W-1:0] rd_d;
   logic [DATA_W-1:0] rd_q;
   logic              ready_q;
   logic              resp_q;

   // pins come from outside the clock domain
   pww_sync #(
      .W (SYNC_W)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_d       ({i_watchdog_fault_n, i_lv_channel_reset_n,
                   i_hv_channel_reset_n, i_watchdog_enable_pin,
                   i_kick_input, i_lv_feedback_good,
                   i_hv_feedback_good}),
      .o_q       (pin_s)
   );

   assign hv_good = pin_s[PIN_FB_HV]; // R01 R02
   assign lv_good = pin_s[PIN_FB_LV]; // R01 R02
   assign kick_s  = pin_s[PIN_KICK];
   assign wden_s  = pin_s[PIN_WDEN];

   pww_por_chan u_hv (
      .i_clk_sys  (i_clk_sys),
      .i_srst     (i_srst),
      .i_good     (hv_good),
      .i_tick     (por_tick),
      .o_released (hv_rel),
      .o_osc_req  (hv_req)
   );

   pww_por_chan u_lv (
      .i_clk_sys  (i_clk_sys),
      .i_srst     (i_srst),
      .i_good     (lv_good),
      .i_tick     (por_tick),
      .o_released (lv_rel),
      .o_osc_req  (lv_req)
   );

   // reset-timing oscillator: a tick every por_div_q system clocks,
   // a divider of zero or one ticks on every clock
   assign por_run  = hv_req || lv_req || wd_st_q == WD_FAULT; // R05 R14
   assign por_tick = por_run &&
                     ({1'b0, por_ph_q} + 17'h00001) >= {1'b0, por_div_q};

   always_ff @(posedge i_clk_sys) begin
      if (i_srst || !por_run || por_tick) begin // R04
         por_ph_q <= '0;
      end else begin
         por_ph_q <= por_ph_q + 16'h0001;
      end
   end

   // watchdog-timing oscillator, phase restarted by each good kick
   assign wd_run  = wd_st_q == WD_HOLD || wd_st_q == WD_WIN; // R07
   assign wd_tick = wd_run &&
                    ({1'b0, wd_ph_q} + 17'h00001) >= {1'b0, wdt_div_q};

   always_ff @(posedge i_clk_sys) begin
      if (i_srst || !wd_run || wd_tick || kick_acc) begin // R13
         wd_ph_q <= '0;
      end else begin
         wd_ph_q <= wd_ph_q + 16'h0001;
      end
   end

   // kick edge detect on the filtered pin
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         kick_prev_q <= 1'b0;
      end else begin
         kick_prev_q <= kick_s;
      end
   end

   assign kick_fall = kick_prev_q && !kick_s; // R08
   assign wd_ok     = wden_s && hv_rel && lv_rel; // R06
   assign kick_acc  = wd_ok && wd_st_q == WD_WIN && kick_fall &&
                      wd_cnt_q >= WIN_LO_CYC;

   // watchdog sequencer; one counter serves hold-off, window and fault
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         wd_st_q  <= WD_IDLE;
         wd_cnt_q <= '0;
      end else if (!wd_ok) begin // R17
         wd_st_q  <= WD_IDLE;
         wd_cnt_q <= '0;
      end else begin
         unique case (wd_st_q)
            WD_IDLE: begin
               wd_st_q  <= WD_HOLD; // R07
               wd_cnt_q <= '0;
            end
            WD_HOLD: begin
               // kick edges have no effect here
               if (wd_tick) begin // R07
                  if (wd_cnt_q == HOLD_CYC - 7'h01) begin
                     wd_st_q  <= WD_WIN; // R19
                     wd_cnt_q <= '0;
                  end else begin
                     wd_cnt_q <= wd_cnt_q + 7'h01;
                  end
               end
            end
            WD_WIN: begin
               if (kick_fall) begin
                  if (wd_cnt_q < WIN_LO_CYC) begin
                     wd_st_q <= WD_FAULT; // R09
                  end
                  wd_cnt_q <= '0; // R13
               end else if (wd_tick) begin
                  if (wd_cnt_q == WIN_HI_CYC - 7'h01) begin
                     wd_st_q  <= WD_FAULT; // R10
                     wd_cnt_q <= '0;
                  end else begin
                     wd_cnt_q <= wd_cnt_q + 7'h01;
                  end
               end
            end
            WD_FAULT: begin
               if (por_tick) begin // R11
                  if (wd_cnt_q == POR_CYC - 7'h01) begin
                     wd_st_q  <= WD_HOLD; // R12
                     wd_cnt_q <= '0;
                  end else begin
                     wd_cnt_q <= wd_cnt_q + 7'h01;
                  end
               end
            end
         endcase
      end
   end

   // open-drain pins: data always low, enable low pulls the wire
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         zero_q     <= 1'b0;
         hv_oe_n_q  <= 1'b0;
         lv_oe_n_q  <= 1'b0;
         wdo_oe_n_q <= 1'b1;
      end else begin
         zero_q     <= 1'b0;
         hv_oe_n_q  <= hv_rel; // R03
         lv_oe_n_q  <= lv_rel; // R03
         wdo_oe_n_q <= wd_st_q != WD_FAULT; // R15 R11 R14
      end
   end

   // events: rising release, first fault cycle, accepted kick
   always_comb begin
      ev            = '0;
      ev[EV_HV_REL] = hv_rel && !hv_oe_n_q;
      ev[EV_LV_REL] = lv_rel && !lv_oe_n_q;
      ev[EV_FAULT]  = wd_st_q == WD_FAULT && wdo_oe_n_q;
      ev[EV_KICK]   = kick_acc;
   end

   assign int_clr = (wr_q && wa_q == OFS_INT_CLR) ?
                    i_hwdata[EV_W-1:0] : '0;

   // a new event wins over a clear in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         int_stat_q <= '0;
         irq_q      <= 1'b0;
      end else begin
         int_stat_q <= (int_stat_q & ~int_clr) | ev;
         irq_q      <= |(int_stat_q & int_en_q);
      end
   end

   // ahb-lite: zero wait states, always okay
   assign ap = i_hsel && i_hready && i_htrans[1];

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         wr_q    <= 1'b0;
         wa_q    <= '0;
         ready_q <= 1'b1;
         resp_q  <= HRESP_OKAY;
      end else begin
         // upper address bits must be zero, as in the read decode
         wr_q    <= ap && i_hwrite && i_hsize == HSIZE_WORD &&
                    i_haddr[31:8] == 24'h000000;
         wa_q    <= i_haddr[7:0];
         ready_q <= 1'b1;
         resp_q  <= HRESP_OKAY;
      end
   end

   // writes land in the data phase; unmapped offsets are dropped
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         por_div_q <= POR_DIV_RST;
         wdt_div_q <= WDT_DIV_RST;
         int_en_q  <= INT_EN_RST;
      end else if (wr_q) begin
         if (wa_q == OFS_POR_DIV) begin
            por_div_q <= i_hwdata[DIV_W-1:0];
         end
         if (wa_q == OFS_WDT_DIV) begin
            wdt_div_q <= i_hwdata[DIV_W-1:0];
         end
         if (wa_q == OFS_INT_EN) begin
            int_en_q <= i_hwdata[EV_W-1:0];
         end
      end
   end

   // read data registered at the address phase, so it stands
   // for the whole data phase
   always_comb begin
      rd_d = '0;
      if (i_haddr[31:8] == 24'h000000) begin
         unique case (i_haddr[7:0])
            OFS_POR_DIV: rd_d[DIV_W-1:0] = por_div_q;
            OFS_WDT_DIV: rd_d[DIV_W-1:0] = wdt_div_q;
            OFS_STATUS: begin
               rd_d[ST_FB_HV]  = hv_good;
               rd_d[ST_FB_LV]  = lv_good;
               rd_d[ST_HV_REL] = hv_rel;
               rd_d[ST_LV_REL] = lv_rel;
               rd_d[ST_WDEN]   = wden_s;
               rd_d[ST_KICK]   = kick_s;
               rd_d[ST_HVPIN]  = pin_s[PIN_HVRST];
               rd_d[ST_LVPIN]  = pin_s[PIN_LVRST];
               rd_d[ST_WDOPIN] = pin_s[PIN_WDO];
            end
            OFS_INT_STAT: rd_d[EV_W-1:0] = int_stat_q;
            OFS_INT_EN:   rd_d[EV_W-1:0] = int_en_q;
            OFS_WD_CNT: begin
               rd_d[CNT_W-1:0]        = wd_cnt_q;
               rd_d[WC_STATE+1:WC_STATE] = wd_st_q;
            end
            default: rd_d = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         rd_q <= '0;
      end else if (ap && !i_hwrite) begin
         rd_q <= rd_d;
      end
   end

   assign o_hrdata                  = rd_q;
   assign o_hreadyout               = ready_q;
   assign o_hresp                   = resp_q;
   assign o_hv_channel_reset_n      = zero_q;
   assign o_lv_channel_reset_n      = zero_q;
   assign o_watchdog_fault_n        = zero_q;
   assign o_hv_channel_reset_n_oe_n = hv_oe_n_q;
   assign o_lv_channel_reset_n_oe_n = lv_oe_n_q;
   assign o_watchdog_fault_n_oe_n   = wdo_oe_n_q;
   assign o_irq                     = irq_q;

   property p_r07;
      @(posedge i_clk_sys) disable iff (i_srst)
      wd_st_q == WD_WIN && $past(wd_st_q) == WD_HOLD |->
         $past(wd_cnt_q) == HOLD_CYC - 7'h01 && $past(wd_tick);
   endproperty
   a_r07: assert property (p_r07) // R07
      else $error("window opened before 33 hold-off cycles");

   property p_r09;
      @(posedge i_clk_sys) disable iff (i_srst)
      wd_ok && wd_st_q == WD_WIN && kick_fall && wd_cnt_q < WIN_LO_CYC
         |=> wd_st_q == WD_FAULT ##1 !o_watchdog_fault_n_oe_n;
   endproperty
   a_r09: assert property (p_r09) // R09
      else $error("early kick did not raise a fault");

   property p_r10;
      @(posedge i_clk_sys) disable iff (i_srst)
      wd_ok && wd_st_q == WD_WIN && wd_tick && !kick_fall &&
         wd_cnt_q == WIN_HI_CYC - 7'h01 |=> wd_st_q == WD_FAULT;
   endproperty
   a_r10: assert property (p_r10) // R10
      else $error("missing kick did not raise a fault");

   property p_r13;
      @(posedge i_clk_sys) disable iff (i_srst)
      kick_acc |=> wd_st_q == WD_WIN && wd_cnt_q == '0 && wd_ph_q == '0;
   endproperty
   a_r13: assert property (p_r13) // R13
      else $error("accepted kick did not restart the count");

   property p_r12;
      @(posedge i_clk_sys) disable iff (i_srst)
      wd_ok && wd_st_q == WD_FAULT && por_tick &&
         wd_cnt_q == POR_CYC - 7'h01 |=> wd_st_q == WD_HOLD
         ##1 o_watchdog_fault_n_oe_n;
   endproperty
   a_r12: assert property (p_r12) // R12
      else $error("fault end did not restart hold-off");

   property p_r11;
      @(posedge i_clk_sys) disable iff (i_srst)
      wd_st_q == WD_HOLD && $past(wd_st_q) == WD_FAULT |->
         $past(wd_cnt_q) == POR_CYC - 7'h01 && $past(por_tick);
   endproperty
   a_r11: assert property (p_r11) // R11
      else $error("fault released before 64 oscillator cycles");

   property p_r14;
      @(posedge i_clk_sys) disable iff (i_srst)
      wd_st_q == WD_WIN |-> !por_run ##1 o_watchdog_fault_n_oe_n;
   endproperty
   a_r14: assert property (p_r14) // R14
      else $error("reset oscillator or fault active in window");

   property p_r17;
      @(posedge i_clk_sys) disable iff (i_srst)
      !wden_s |=> wd_st_q == WD_IDLE ##1 o_watchdog_fault_n_oe_n;
   endproperty
   a_r17: assert property (p_r17) // R17
      else $error("disabled watchdog not idle and released");

endmodule

// file: pww_mcu_model.sv
// supervised processor model: kicks while both reset lines are released
`timescale 1ns/1ps
module pww_mcu_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_wire_n,
   input  wire logic [7:0] i_period,
   output logic            o_kick
);
   logic [7:0] cnt_q;
   // a processor in reset leaves the kick line idle high
   always @(posedge i_clk_sys) begin
      if (i_rst_wire_n !== 1'b1 || i_period == 8'h00) begin
         cnt_q  <= 8'h00;
         o_kick <= 1'b1;
      end else begin
         cnt_q  <= (cnt_q == i_period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
         // half-period low pulses, wide enough for the input filter
         o_kick <= (cnt_q >= (i_period >> 1));
      end
   end
endmodule

// file: pww_top_tb.sv
// testbench: reset timing, window watchdog and interrupts over ahb-lite
`timescale 1ns/1ps
module pww_top_tb;
   import pww_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic        hrdy;
   logic        hresp;
   logic        hv_good = 1'b0;
   logic        lv_good = 1'b0;
   logic        wden = 1'b0;
   logic [7:0]  period = 8'h28;
   logic        kick;
   logic        hv_o, hv_oe, lv_o, lv_oe, wd_o, wd_oe, irq;
   wire logic   hv_w = hv_oe ? 1'b1 : hv_o;
   wire logic   lv_w = lv_oe ? 1'b1 : lv_o;
   wire logic   wd_w = wd_oe ? 1'b1 : wd_o;
   wire logic [3:0] obs = {irq, wd_oe, lv_oe, hv_oe};
   int          error_cnt = 0;
   int          compares = 0;
   int          n;
   logic [31:0] d;
   always #12.5 clk = ~clk;
   pww_top dut_u (
      .i_clk_sys(clk), .i_srst(srst), .i_hsel(1'b1), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(HSIZE_WORD),
      .i_hready(hrdy), .i_hwdata(hwdata), .o_hrdata(hrdata),
      .o_hreadyout(hrdy), .o_hresp(hresp),
      .i_hv_feedback_good(hv_good), .i_lv_feedback_good(lv_good),
      .i_kick_input(kick), .i_watchdog_enable_pin(wden),
      .i_hv_channel_reset_n(hv_w), .o_hv_channel_reset_n(hv_o),
      .o_hv_channel_reset_n_oe_n(hv_oe),
      .i_lv_channel_reset_n(lv_w), .o_lv_channel_reset_n(lv_o),
      .o_lv_channel_reset_n_oe_n(lv_oe),
      .i_watchdog_fault_n(wd_w), .o_watchdog_fault_n(wd_o),
      .o_watchdog_fault_n_oe_n(wd_oe), .o_irq(irq)
   );
   pww_mcu_model mcu_u (
      .i_clk_sys(clk), .i_rst_wire_n(hv_w & lv_w), .i_period(period),
      .o_kick(kick)
   );
   task print_verdict;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task in_range(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask
   // the master never assumes a latency; it waits on hready
   task wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hrdy !== 1'b1 && k < 50);
      if (hrdy !== 1'b1) begin
         error_cnt++;
         print_verdict;
      end
   endtask
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask
   task rd_chk(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, d);
      chk(d, exp);
   endtask
   task wr(input logic [31:0] a, input logic [31:0] v);
      ahb(1'b1, a, v, d);
   endtask
   // counts edges until the observed pin reaches level v, or lim
   task wait_sig(input int s, input logic v, input int lim);
      n = 0;
      while (obs[s] !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task idle(input int c);
      repeat (c) @(posedge clk);
   endtask
   initial begin
      idle(8);
      srst <= 1'b0;
      @(posedge clk);
      rd_chk({24'h0, OFS_POR_DIV}, {16'h0, POR_DIV_RST});
      rd_chk({24'h0, OFS_WDT_DIV}, {16'h0, WDT_DIV_RST});
      wr({24'h0, OFS_WDT_DIV}, 32'h3);
      rd_chk({24'h0, OFS_WDT_DIV}, 32'h3);
      wr({24'h0, OFS_WDT_DIV}, {16'h0, WDT_DIV_RST});
      rd_chk({24'h0, OFS_INT_EN}, 32'h0);
      rd_chk(32'h40, 32'h0);
      // resets pulled low, fault released, kick idle high
      rd_chk({24'h0, OFS_STATUS}, 32'h120);
      chk(hresp, HRESP_OKAY);
      chk({hv_o, lv_o, wd_o}, 3'h0);
      chk({hv_oe, lv_oe, wd_oe, irq}, 4'h2);
      $display("test reset values done");
      wr({24'h0, OFS_POR_DIV}, 32'h1);
      wden <= 1'b1;
      hv_good <= 1'b1;
      wait_sig(0, 1'b1, 200);
      in_range(n, POR_CYC + 3, POR_CYC + 7);
      chk(lv_oe, 1'b0);
      chk(irq, 1'b0);
      rd_chk({24'h0, OFS_INT_STAT}, 32'h1);
      wr({24'h0, OFS_INT_EN}, 32'hf);
      idle(3);
      chk(irq, 1'b1);
      wr({24'h0, OFS_INT_CLR}, 32'h1);
      idle(3);
      chk(irq, 1'b0);
      rd_chk({24'h0, OFS_INT_STAT}, 32'h0);
      $display("test channel release done");
      lv_good <= 1'b1;
      wait_sig(1, 1'b1, 200);
      in_range(n, POR_CYC + 3, POR_CYC + 7);
      // kicks also arrive during hold-off and must be ignored
      wait_sig(2, 1'b0, 1000);
      chk(n, 1000);
      ahb(1'b0, {24'h0, OFS_INT_STAT}, 32'h0, d);
      chk(d[3:0], 4'ha);
      ahb(1'b0, {24'h0, OFS_WD_CNT}, 32'h0, d);
      chk(d[9:8], 2'h2);
      $display("test good kicks done");
      period <= 8'h08;
      wait_sig(2, 1'b0, 300);
      chk({31'h0, n < 300}, 32'h1);
      period <= 8'h00;
      wait_sig(2, 1'b1, 200);
      in_range(n, POR_CYC - 2, POR_CYC + 2);
      wait_sig(2, 1'b0, 600);
      in_range(n, 4 * (HOLD_CYC + WIN_HI_CYC) - 4,
               4 * (HOLD_CYC + WIN_HI_CYC) + 6);
      wait_sig(2, 1'b1, 200);
      in_range(n, POR_CYC - 2, POR_CYC + 2);
      $display("test window faults done");
      wden <= 1'b0;
      idle(10);
      period <= 8'h08;
      wait_sig(2, 1'b0, 600);
      chk(n, 600);
      ahb(1'b0, {24'h0, OFS_WD_CNT}, 32'h0, d);
      chk(d[9:8], 2'h0);
      $display("test disabled watchdog done");
      hv_good <= 1'b0;
      wait_sig(0, 1'b0, 20);
      chk({31'h0, n < 20}, 32'h1);
      chk(lv_oe, 1'b1);
      hv_good <= 1'b1;
      wait_sig(0, 1'b1, 200);
      in_range(n, POR_CYC + 3, POR_CYC + 7);
      $display("test good flag drop done");
      print_verdict;
   end
endmodule
